// [src/ric_cfg.svh]
// Offsets, field positions, reset values, vectors and timing counts
`ifndef RIC_CFG_SVH
`define RIC_CFG_SVH

`define REG_TMR_CTRL 8'h08
`define REG_SYS_CTRL 8'h0C
`define SYS_CTRL_RST 8'h10
`define SYS_KBD_EN 7
`define SYS_KBD_CLR 6
`define SYS_EXT_EN 4
`define SYS_DROOP_EN 3
`define SYS_EXT2_FLAG 1
`define SYS_EXT2_EN 0
`define TMR_CTRL_RST 8'h40
`define TMR_FLAG 7
`define TMR_MASK 6
`define CCR_I_BIT 3

`define VEC_RESET_HI 16'h1FFE
`define VEC_RESET_LO 16'h1FFF
`define VEC_SWI_HI 16'h1FFC
`define VEC_SWI_LO 16'h1FFD
`define VEC_EXT_HI 16'h1FFA
`define VEC_EXT_LO 16'h1FFB
`define VEC_EXT2_HI 16'h1FF8
`define VEC_EXT2_LO 16'h1FF9
`define VEC_TMR_HI 16'h1FF6
`define VEC_TMR_LO 16'h1FF7
`define VEC_KBD_HI 16'h1FF4
`define VEC_KBD_LO 16'h1FF5

`define STACK_PAGE 10'b0000000011
`define SP_RESET 6'h3F
`define CTX_BYTES 3'd5
`define CTX_LAST 3'd4

`define CLK_PERIOD_NS 5
`define BUS_CYCLE_NS 5
`define EXT_RST_MIN_TENTHS 15
`define EXT_RST_MIN_CYC ((`EXT_RST_MIN_TENTHS * `BUS_CYCLE_NS + 10 * `CLK_PERIOD_NS - 1) / (10 * `CLK_PERIOD_NS))
`define POWER_UP_HOLD_CYCLES 4096

`endif

// [src/ric_pkg.sv]
// Types shared by the reset and interrupt control block
package ric_pkg;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] condition_flags_register;
  } ctx_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } mem_req_t;

  typedef enum logic [2:0] {
    SRC_RESET, SRC_SWI, SRC_EXT, SRC_EXT2, SRC_TMR, SRC_KBD
  } src_t;

  typedef enum logic [2:0] {
    ST_RESET, ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_IDLE, ST_PUSH, ST_PULL
  } state_t;

endpackage

// [src/req_latch.sv]
// Sticky request flag; a set in the same cycle as a clear wins
`timescale 1ns/100ps
module req_latch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end

endmodule

// [src/run_counter.sv]
// Counts cycles while run is high, saturating at LIMIT; restarts when run drops
`timescale 1ns/100ps
module run_counter #(
  parameter int W = 13,
  parameter logic [W-1:0] LIMIT = 13'd4096
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic reached
);

  logic [W-1:0] cnt_ff;

  assign reached = (cnt_ff == LIMIT);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (!run)
      cnt_ff <= '0;
    else if (!reached)
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
  end

endmodule

// [src/reset_interrupt_control.sv]
// Reset merging, interrupt deferral and vectoring, and stack window control
//
// Behaviour
// RULE1: Power-up, reset pin or enabled droop resets.
// RULE2: Any reset loads vector $1FFE/$1FFF, sets mask.
// RULE3: Hold reset power-up cycles, pulling pin low.
// RULE4: Pin still low after hold keeps reset.
// RULE5: External reset pulse lasts at least 1.5 cycles.
// RULE6: Droop reset only when enable bit 3 set.
// RULE7: Software keeps droop reset off at 3V.
// RULE8: Software trap plus four maskable hardware requests.
// RULE9: Mask flag set blocks every maskable request.
// RULE10: Interrupt entry stacks context, then sets mask.
// RULE11: Return-from-trap pulls context back, resumes execution.
// RULE12: Requests wait for instruction end, then serviced.
// RULE13: Timer zero sets flag; gated by two masks.
// RULE14: Timer service fetches vector $1FF6/$1FF7 after stacking.
// RULE15: Flag sticky until cleared; timer write discards request.
// RULE16: Reset and stack reload set pointer $00FF.
// RULE17: Push decrements pointer, pull increments it.
// RULE18: Stack confined to $00C0-$00FF, wraps past 64.
// RULE19: Interrupt uses five bytes, call uses two.
// RULE20: Priority: reset, trap, external, timer, keyboard.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "ric_cfg.svh"
module reset_interrupt_control #(
  parameter int POWER_UP_HOLD_CYCLES = `POWER_UP_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  input wire logic droop_detect,
  input wire logic ext_req_b,
  input wire logic ext_req2_b,
  input wire logic kbd_event,
  input wire logic timer_zero,
  input wire logic timer_write,
  input wire logic insn_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic rsp_exec,
  input wire logic sp_push,
  input wire logic sp_pull,
  input wire logic ccr_i_wr,
  input wire logic ccr_i_val,
  input wire ric_pkg::ctx_t ctx_i,
  output ric_pkg::ctx_t ctx_o,
  output logic ctx_restore,
  output logic [15:0] pc_value,
  output logic pc_load,
  output logic cpu_hold,
  output logic i_mask,
  output logic [15:0] stack_addr,
  output ric_pkg::mem_req_t mem_o,
  input wire logic [7:0] mem_rdata
);
  import ric_pkg::*;

  localparam int PW = $clog2(POWER_UP_HOLD_CYCLES + 1);
  localparam logic [PW-1:0] POR_LIMIT = PW'(POWER_UP_HOLD_CYCLES);
  localparam logic [1:0] PIN_LIMIT = 2'(`EXT_RST_MIN_CYC);
  localparam logic [7:0] TMR_RST_VAL = `TMR_CTRL_RST;

  state_t state_ff, nxt_state;
  src_t src_ff, nxt_src;
  logic [5:0] sp_ff;
  logic [2:0] idx_ff;
  logic [7:0] sys_ctrl_ff;
  logic tmr_mask_ff;
  logic i_mask_ff;
  logic ext_prev_ff, ext2_prev_ff;
  logic pc_load_ff, ctx_restore_ff;
  logic [7:0] rdata_ff;
  ctx_t ctx_ff;
  logic [15:0] pc_ff;

  // Reset sources
  wire por_done;
  wire pin_low_seen;
  wire in_rst = (state_ff == ST_RESET);
  wire droop_rst = droop_detect & sys_ctrl_ff[`SYS_DROOP_EN]; // [RULE6]
  wire any_rst = ~por_done | pin_low_seen | droop_rst; // [RULE1]

  run_counter #(.W(PW), .LIMIT(POR_LIMIT)) u_por_hold (
    .clk(clk),
    .rst_b(rst_b),
    .run(1'b1),
    .reached(por_done)
  );

  // Pin must read low for the minimum pulse width before it counts
  run_counter #(.W(2), .LIMIT(PIN_LIMIT)) u_pin_filter (
    .clk(clk),
    .rst_b(rst_b),
    .run(~rst_pin_i),
    .reached(pin_low_seen) // [RULE5]
  );

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = ~por_done; // [RULE3]

  // Register decode
  wire sys_hit = (reg_addr == `REG_SYS_CTRL);
  wire tmr_hit = (reg_addr == `REG_TMR_CTRL);
  wire sys_wr = reg_wr & sys_hit;
  wire tmr_wr = reg_wr & tmr_hit;

  // Request latches
  wire ext_q, ext2_q, kbd_q, tmr_flag_q, tmr_pend_q;
  wire boundary = insn_done & (state_ff == ST_IDLE);
  wire take_rti = boundary & rti_exec; // [RULE11]
  wire take_swi = boundary & ~rti_exec & swi_exec; // [RULE8]
  wire ext_req = ext_q & sys_ctrl_ff[`SYS_EXT_EN];
  wire ext2_req = ext2_q & sys_ctrl_ff[`SYS_EXT2_EN];
  wire tmr_req = tmr_flag_q & tmr_pend_q & ~tmr_mask_ff; // [RULE13]
  wire kbd_req = kbd_q & sys_ctrl_ff[`SYS_KBD_EN];
  wire [3:0] hw_req = {kbd_req, tmr_req, ext2_req, ext_req};
  wire take_hw = boundary & ~rti_exec & ~swi_exec & ~i_mask_ff & (|hw_req); // [RULE9] [RULE12]
  wire served_ext = take_hw & ext_req; // [RULE20]
  wire served_ext2 = take_hw & ~ext_req & ext2_req;
  wire served_tmr = take_hw & ~ext_req & ~ext2_req & tmr_req;
  wire served_kbd = take_hw & ~ext_req & ~ext2_req & ~tmr_req & kbd_req;

  req_latch u_ext (
    .clk(clk),
    .rst_b(rst_b),
    .set(ext_prev_ff & ~ext_req_b),
    .clr(in_rst | served_ext),
    .q(ext_q)
  );

  req_latch u_ext2 (
    .clk(clk),
    .rst_b(rst_b),
    .set(ext2_prev_ff & ~ext_req2_b),
    .clr(in_rst | served_ext2 | (sys_wr & ~reg_wdata[`SYS_EXT2_FLAG])),
    .q(ext2_q)
  );

  req_latch u_kbd (
    .clk(clk),
    .rst_b(rst_b),
    .set(kbd_event),
    .clr(in_rst | served_kbd | (sys_wr & reg_wdata[`SYS_KBD_CLR])),
    .q(kbd_q)
  );

  req_latch u_tmr_flag (
    .clk(clk),
    .rst_b(rst_b),
    .set(timer_zero),
    .clr(in_rst | (tmr_wr & ~reg_wdata[`TMR_FLAG])), // [RULE15]
    .q(tmr_flag_q)
  );

  req_latch u_tmr_pend (
    .clk(clk),
    .rst_b(rst_b),
    .set(timer_zero),
    .clr(in_rst | served_tmr | timer_write), // [RULE15]
    .q(tmr_pend_q)
  );

  // Vector selection
  logic [15:0] vec_hi, vec_lo;
  always_comb
  begin
    case (src_ff)
      SRC_RESET: begin vec_hi = `VEC_RESET_HI; vec_lo = `VEC_RESET_LO; end // [RULE2]
      SRC_SWI: begin vec_hi = `VEC_SWI_HI; vec_lo = `VEC_SWI_LO; end
      SRC_EXT: begin vec_hi = `VEC_EXT_HI; vec_lo = `VEC_EXT_LO; end
      SRC_EXT2: begin vec_hi = `VEC_EXT2_HI; vec_lo = `VEC_EXT2_LO; end
      SRC_TMR: begin vec_hi = `VEC_TMR_HI; vec_lo = `VEC_TMR_LO; end // [RULE14]
      SRC_KBD: begin vec_hi = `VEC_KBD_HI; vec_lo = `VEC_KBD_LO; end
      default: begin vec_hi = `VEC_RESET_HI; vec_lo = `VEC_RESET_LO; end
    endcase
  end

  // Context byte to stack, in push order: PC low, PC high, X, A, CONDITION_FLAGS_REGISTER
  logic [7:0] push_byte;
  always_comb
  begin
    case (idx_ff)
      3'd0: push_byte = ctx_ff.pc[7:0];
      3'd1: push_byte = ctx_ff.pc[15:8];
      3'd2: push_byte = ctx_ff.x;
      3'd3: push_byte = ctx_ff.a;
      default: push_byte = ctx_ff.condition_flags_register;
    endcase
  end

  // Stack window
  wire [5:0] sp_up = sp_ff + 6'h01;
  wire cpu_idle = (state_ff == ST_IDLE);
  assign stack_addr = {`STACK_PAGE, sp_ff}; // [RULE18]

  // Memory requests
  wire pushing = (state_ff == ST_PUSH);
  wire pulling = (state_ff == ST_PULL) & (idx_ff != `CTX_BYTES);
  assign mem_o.we = pushing;
  assign mem_o.wdata = push_byte;
  assign mem_o.re = pulling | (state_ff == ST_VEC_HI) | (state_ff == ST_VEC_LO);
  assign mem_o.addr = pushing ? stack_addr :
                      pulling ? {`STACK_PAGE, sp_up} :
                      (state_ff == ST_VEC_HI) ? vec_hi : vec_lo;

  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    case (state_ff)
      ST_RESET:
        if (~any_rst & rst_pin_i) // [RULE4]
          nxt_state = ST_VEC_HI;
      ST_VEC_HI: nxt_state = ST_VEC_LO;
      ST_VEC_LO: nxt_state = ST_VEC_END;
      ST_VEC_END: nxt_state = ST_IDLE;
      ST_IDLE:
        if (take_rti)
          nxt_state = ST_PULL;
        else if (take_swi | take_hw)
        begin
          nxt_state = ST_PUSH;
          nxt_src = take_swi ? SRC_SWI : served_ext ? SRC_EXT : served_ext2 ? SRC_EXT2 :
                    served_tmr ? SRC_TMR : SRC_KBD; // [RULE20]
        end
      ST_PUSH:
        if (idx_ff == `CTX_LAST) // [RULE19]
          nxt_state = ST_VEC_HI;
      ST_PULL:
        if (idx_ff == `CTX_BYTES)
          nxt_state = ST_IDLE;
      default: nxt_state = ST_RESET;
    endcase
    if (any_rst)
    begin
      nxt_state = ST_RESET;
      nxt_src = SRC_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_RESET;
      src_ff <= SRC_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idx_ff <= 3'd0;
    else if (pushing | (state_ff == ST_PULL))
      idx_ff <= (nxt_state == state_ff) ? idx_ff + 3'd1 : 3'd0;
    else
      idx_ff <= 3'd0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sp_ff <= `SP_RESET;
    else if (in_rst | (cpu_idle & rsp_exec)) // [RULE16]
      sp_ff <= `SP_RESET;
    else if (pushing | (cpu_idle & sp_push)) // [RULE17]
      sp_ff <= sp_ff - 6'h01;
    else if (pulling | (cpu_idle & sp_pull)) // [RULE17]
      sp_ff <= sp_up;
  end

  // Interrupt mask flag
  wire ccr_back = (state_ff == ST_PULL) & (idx_ff == 3'd1);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      i_mask_ff <= 1'b1;
    else if (in_rst | (pushing & (idx_ff == `CTX_LAST))) // [RULE2] [RULE10]
      i_mask_ff <= 1'b1;
    else if (ccr_back) // [RULE11]
      i_mask_ff <= mem_rdata[`CCR_I_BIT];
    else if (cpu_idle & ccr_i_wr)
      i_mask_ff <= ccr_i_val; // [RULE9]
  end

  // Context capture and restore, pulled in order CONDITION_FLAGS_REGISTER, A, X, PC high, PC low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctx_ff <= '0;
    else if (take_swi | take_hw)
      ctx_ff <= ctx_i; // [RULE10]
    else if (state_ff == ST_PULL)
      case (idx_ff)
        3'd1: ctx_ff.condition_flags_register <= mem_rdata;
        3'd2: ctx_ff.a <= mem_rdata;
        3'd3: ctx_ff.x <= mem_rdata;
        3'd4: ctx_ff.pc[15:8] <= mem_rdata;
        3'd5: ctx_ff.pc[7:0] <= mem_rdata;
        default: ctx_ff <= ctx_ff;
      endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pc_ff <= 16'h0000;
    else if (state_ff == ST_VEC_LO)
      pc_ff[15:8] <= mem_rdata;
    else if (state_ff == ST_VEC_END)
      pc_ff[7:0] <= mem_rdata;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_load_ff <= 1'b0;
      ctx_restore_ff <= 1'b0;
      ext_prev_ff <= 1'b1;
      ext2_prev_ff <= 1'b1;
    end
    else
    begin
      pc_load_ff <= (state_ff == ST_VEC_END) & ~any_rst;
      ctx_restore_ff <= (state_ff == ST_PULL) & (idx_ff == `CTX_BYTES) & ~any_rst;
      ext_prev_ff <= ext_req_b;
      ext2_prev_ff <= ext_req2_b;
    end
  end

  // Control registers, returned to reset values by every reset source
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sys_ctrl_ff <= `SYS_CTRL_RST;
      tmr_mask_ff <= TMR_RST_VAL[`TMR_MASK];
    end
    else if (in_rst)
    begin
      sys_ctrl_ff <= `SYS_CTRL_RST;
      tmr_mask_ff <= TMR_RST_VAL[`TMR_MASK];
    end
    else
    begin
      if (sys_wr)
        sys_ctrl_ff <= reg_wdata;
      if (tmr_wr)
        tmr_mask_ff <= reg_wdata[`TMR_MASK];
    end
  end

  // Read path: flag bits show live state, the clear bit reads zero
  wire [7:0] sys_rd = {sys_ctrl_ff[7], 1'b0, sys_ctrl_ff[5:2], ext2_q, sys_ctrl_ff[0]};
  wire [7:0] tmr_rd = {tmr_flag_q, tmr_mask_ff, 6'h00};
  wire [7:0] rd_mux = sys_hit ? sys_rd : tmr_hit ? tmr_rd : 8'h00;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= rd_mux;
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata = rdata_ff;
  assign ctx_o = ctx_ff;
  assign ctx_restore = ctx_restore_ff;
  assign pc_value = pc_ff;
  assign pc_load = pc_load_ff;
  assign cpu_hold = ~cpu_idle | pc_load_ff | ctx_restore_ff;
  assign i_mask = i_mask_ff;

endmodule

// [sim/ric_mem_model.sv]
// Memory behind the block: vector bytes and the stack page
`timescale 1ns/100ps
module ric_mem_model (
  input wire logic clk,
  input wire ric_pkg::mem_req_t req,
  output logic [7:0] rdata
);
  import ric_pkg::*;
  logic [7:0] mem [logic [15:0]];
  initial
  begin
    rdata = 8'h00;
    for (int a = 16'h1FF4; a <= 16'h1FFF; a++)
      mem[a[15:0]] = a[7:0] ^ 8'h5A;
  end
  // Data one cycle after a read, otherwise a pattern that keeps changing
  always @(posedge clk)
  begin
    if (req.we)
      mem[req.addr] = req.wdata;
    if (req.re)
      rdata <= mem.exists(req.addr) ? mem[req.addr] : 8'hEE;
    else
      rdata <= ~rdata;
  end
endmodule

// [sim/reset_interrupt_control_monitor.sv]
// Concurrent checks on the reset and interrupt control ports
`timescale 1ns/100ps
`include "ric_cfg.svh"
module reset_interrupt_control_monitor #(
  parameter int POWER_UP_HOLD_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rst_pin_oe,
  input wire logic insn_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic sp_push,
  input wire logic sp_pull,
  input wire ric_pkg::mem_req_t mem_o,
  input wire logic ctx_restore,
  input wire logic pc_load,
  input wire logic cpu_hold,
  input wire logic i_mask,
  input wire logic [15:0] stack_addr
);
  import ric_pkg::*;
  int hold_cnt;
  logic take;
  assign take = insn_done && !cpu_hold;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hold_cnt <= 0;
    else if (rst_pin_oe)
      hold_cnt <= hold_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_hold_count: assert property ($fell(rst_pin_oe) |-> hold_cnt inside
    {[POWER_UP_HOLD_CYCLES-1:POWER_UP_HOLD_CYCLES+1]}) else $error("hold length");
  a_load_pin_free: assert property (pc_load |-> !rst_pin_oe)
    else $error("load during hold");
  a_load_pulse: assert property (pc_load |=> !pc_load) else $error("load too long");
  a_stack_window: assert property (stack_addr[15:6] == `STACK_PAGE)
    else $error("stack page");
  a_push_down: assert property (sp_push && !cpu_hold && !take |=>
    stack_addr[5:0] == $past(stack_addr[5:0]) - 6'd1) else $error("push");
  a_pull_up: assert property (sp_pull && !cpu_hold && !take |=>
    stack_addr[5:0] == $past(stack_addr[5:0]) + 6'd1) else $error("pull");
  a_trap_entry: assert property (take && swi_exec && !rti_exec |=> mem_o.we [*5] ##1
    (mem_o.re && mem_o.addr == `VEC_SWI_HI && i_mask)) else $error("trap entry");
  a_masked_ignored: assert property (take && i_mask && !swi_exec && !rti_exec
    |=> !cpu_hold) else $error("masked taken");
  a_return_restore: assert property (take && rti_exec |-> ##7 ctx_restore)
    else $error("restore late");
  c_load: cover property (pc_load);
  c_restore: cover property (ctx_restore);
  c_hold_end: cover property ($fell(rst_pin_oe));
endmodule
bind reset_interrupt_control reset_interrupt_control_monitor #(
  .POWER_UP_HOLD_CYCLES(POWER_UP_HOLD_CYCLES)
) i_mon (.clk(clk), .rst_b(rst_b), .rst_pin_oe(rst_pin_oe), .insn_done(insn_done),
  .swi_exec(swi_exec), .rti_exec(rti_exec), .sp_push(sp_push), .sp_pull(sp_pull),
  .mem_o(mem_o), .ctx_restore(ctx_restore), .pc_load(pc_load), .cpu_hold(cpu_hold),
  .i_mask(i_mask), .stack_addr(stack_addr));

// [sim/reset_interrupt_control_bench.sv]
// Self-checking bench for the reset and interrupt control block
`timescale 1ns/100ps
`include "ric_cfg.svh"
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module reset_interrupt_control_bench;
  import ric_pkg::*;
  typedef struct packed { logic wr; logic [7:0] a; logic [7:0] d; } row_t;
  row_t rows [11] = '{'{0, 8'h0C, 8'h10}, '{0, 8'h08, 8'h40}, '{0, 8'h04, 8'h00},
    '{1, 8'h04, 8'hFF}, '{0, 8'h04, 8'h00}, '{1, 8'h0C, 8'h6D}, '{0, 8'h0C, 8'h2D},
    '{1, 8'h08, 8'hFF}, '{0, 8'h08, 8'h40}, '{1, 8'h0C, 8'h91}, '{0, 8'h0C, 8'h91}};
  logic [15:0] pv [4] = '{`VEC_EXT_HI, `VEC_EXT2_HI, `VEC_TMR_HI, `VEC_KBD_HI};
  logic [7:0] ca [4] = '{8'h0C, 8'h0C, 8'h08, 8'h0C};
  logic [7:0] cd [4] = '{8'h93, 8'h91, 8'h00, 8'hD1};
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rst_pin_i = 0, droop_detect = 0;
  logic ext_req_b = 1, ext_req2_b = 1, kbd_event = 0, timer_zero = 0, timer_write = 0;
  logic insn_done = 0, swi_exec = 0, rti_exec = 0, rsp_exec = 0, sp_push = 0, sp_pull = 0;
  logic ccr_i_wr = 0, ccr_i_val = 0, ctx_restore, pc_load, cpu_hold, i_mask;
  logic rst_pin_o, rst_pin_oe;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata, v;
  logic [15:0] pc_value, stack_addr;
  ctx_t ctx_i = 40'hABCD112208;
  ctx_t ctx_o;
  mem_req_t mem_o;
  int miscompares = 0, compares = 0, cycles = 0;
  always #2.5 clk = ~clk;
  reset_interrupt_control #(.POWER_UP_HOLD_CYCLES(8)) i_dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .droop_detect(droop_detect), .ext_req_b(ext_req_b),
    .ext_req2_b(ext_req2_b), .kbd_event(kbd_event), .timer_zero(timer_zero),
    .timer_write(timer_write), .insn_done(insn_done), .swi_exec(swi_exec),
    .rti_exec(rti_exec), .rsp_exec(rsp_exec), .sp_push(sp_push), .sp_pull(sp_pull),
    .ccr_i_wr(ccr_i_wr), .ccr_i_val(ccr_i_val), .ctx_i(ctx_i), .ctx_o(ctx_o),
    .ctx_restore(ctx_restore), .pc_value(pc_value), .pc_load(pc_load),
    .cpu_hold(cpu_hold), .i_mask(i_mask), .stack_addr(stack_addr), .mem_o(mem_o),
    .mem_rdata(mem_rdata));
  ric_mem_model i_mem (.clk(clk), .req(mem_o), .rdata(mem_rdata));
  function automatic logic [15:0] vec(input logic [15:0] h);
    return {h[7:0] ^ 8'h5A, h[7:0] ^ 8'h5B};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic ins(input logic s, input logic r);
    @(posedge clk);
    insn_done <= 1'b1;
    swi_exec <= s;
    rti_exec <= r;
    @(posedge clk);
    insn_done <= 1'b0;
    swi_exec <= 1'b0;
    rti_exec <= 1'b0;
    #1;
  endtask
  task automatic cm;
    @(posedge clk);
    ccr_i_wr <= 1'b1;
    @(posedge clk);
    ccr_i_wr <= 1'b0;
  endtask
  // Waits for the load pulse, or the restore pulse when rs is set
  task automatic wt(input bit rs);
    int n;
    n = 0;
    while ((rs ? ctx_restore : pc_load) !== 1'b1 && n < 80)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CK("handshake", 1'b1, (rs ? ctx_restore : pc_load))
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    `CK("reset sp", 16'h00FF, stack_addr)
    `CK("reset mask", 1'b1, i_mask)
    `CK("pin pulled", 1'b1, rst_pin_oe)
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (16) @(posedge clk);
    #1;
    `CK("pin held", 1'b1, cpu_hold)
    `CK("pin free", 1'b0, rst_pin_oe)
    `CK("pin drive", 1'b0, rst_pin_o)
    @(posedge clk);
    rst_pin_i <= 1'b1;
    wt(0);
    `CK("reset pc", vec(`VEC_RESET_HI), pc_value)
    done("power_up");
    foreach (rows[i])
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
      begin
        rd(rows[i].a, v);
        `CK("register", rows[i].d, v)
      end
    done("registers");
    ins(1'b1, 1'b0);
    wt(0);
    `CK("trap pc", vec(`VEC_SWI_HI), pc_value)
    `CK("trap sp", 16'h00FA, stack_addr)
    ins(1'b0, 1'b1);
    wt(1);
    `CK("context", 40'hABCD112208, ctx_o)
    `CK("return sp", 16'h00FF, stack_addr)
    done("trap");
    wr(8'h08, 8'h00);
    @(posedge clk);
    ext_req_b <= 1'b0;
    ext_req2_b <= 1'b0;
    kbd_event <= 1'b1;
    timer_zero <= 1'b1;
    @(posedge clk);
    ext_req_b <= 1'b1;
    ext_req2_b <= 1'b1;
    kbd_event <= 1'b0;
    timer_zero <= 1'b0;
    ins(1'b0, 1'b0);
    `CK("masked", 1'b0, cpu_hold)
    rd(8'h08, v);
    `CK("timer flag", 8'h80, v)
    for (int k = 0; k < 4; k++)
    begin
      cm();
      ins(1'b0, 1'b0);
      wt(0);
      `CK("vector", vec(pv[k]), pc_value)
      `CK("entry mask", 1'b1, i_mask)
      wr(ca[k], cd[k]);
    end
    `CK("four entries", 16'h00EB, stack_addr)
    done("priority");
    cm();
    @(posedge clk);
    timer_zero <= 1'b1;
    @(posedge clk);
    timer_zero <= 1'b0;
    timer_write <= 1'b1;
    @(posedge clk);
    timer_write <= 1'b0;
    ins(1'b0, 1'b0);
    `CK("discarded", 1'b0, cpu_hold)
    rd(8'h08, v);
    `CK("flag kept", 8'h80, v)
    done("timer_write");
    @(posedge clk);
    sp_push <= 1'b1;
    repeat (65) @(posedge clk);
    sp_push <= 1'b0;
    #1;
    `CK("wrap", 16'h00EA, stack_addr)
    sp_pull <= 1'b1;
    repeat (2) @(posedge clk);
    sp_pull <= 1'b0;
    rsp_exec <= 1'b1;
    #1;
    `CK("pull", 16'h00EC, stack_addr)
    @(posedge clk);
    rsp_exec <= 1'b0;
    #1;
    `CK("reload", 16'h00FF, stack_addr)
    done("stack");
    // Droop stays off until enabled, as for low supply operation
    droop_detect <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CK("droop off", 1'b0, cpu_hold)
    wr(8'h0C, 8'h99);
    @(posedge clk);
    droop_detect <= 1'b0;
    wt(0);
    `CK("droop pc", vec(`VEC_RESET_HI), pc_value)
    rd(8'h0C, v);
    `CK("droop reinit", 8'h10, v)
    done("droop");
    @(posedge clk);
    rst_pin_i <= 1'b0;
    repeat (2) @(posedge clk);
    rst_pin_i <= 1'b1;
    wt(0);
    `CK("pin pc", vec(`VEC_RESET_HI), pc_value)
    `CK("pin mask", 1'b1, i_mask)
    done("pin_reset");
    stop_test();
  end
endmodule
